// ---- inc/vust_defs.vh ----
// Constants for the vector upper-half state tracker
`ifndef VUST_DEFS_VH
`define VUST_DEFS_VH
// Tracker states
`define VUST_ST_CLEAN 2'h0
`define VUST_ST_MOD 2'h1
`define VUST_ST_PRES 2'h2
// Instruction classes
`define VUST_OP_NONE 3'h0
`define VUST_OP_LEGACY 3'h1
`define VUST_OP_WIDE128 3'h2
`define VUST_OP_WIDE256 3'h3
`define VUST_OP_CLRUP 3'h4
`define VUST_OP_RSTOR 3'h5
`define VUST_OP_CLRALL 3'h6
`define VUST_OP_SAVE 3'h7
// Penalty codes
`define VUST_PEN_NONE 3'h0
`define VUST_PEN_A 3'h1
`define VUST_PEN_B 3'h2
`define VUST_PEN_C 3'h3
`define VUST_PEN_D 3'h4
// Register count and index width
`define VUST_NREG 16
`define VUST_IDXW 4
// Reset value of per-register dirty mask
`define VUST_MASK_RST 16'h0000
// Reset values of the single-bit flags
`define VUST_FLAG_RST 1'h0
`define VUST_ZERO_RST 1'h1
`endif

// ---- rtl/vust_next_state.v ----
// Next-state and penalty lookup of the upper-half tracker
`timescale 1ns/1ns
`default_nettype none
`include "vust_defs.vh"
module vust_next_state
(
   input wire [1:0] state_i,
   input wire [2:0] op_i,
   input wire later_i,
   input wire image_dirty_i,
   output reg [1:0] nxt_state_o,
   output reg [2:0] penalty_o
);
   // Transition table for both implementations
   always @*
   begin
      nxt_state_o = state_i;
      penalty_o = `VUST_PEN_NONE;
      case (op_i)
         `VUST_OP_LEGACY:
         begin
            if (state_i == `VUST_ST_MOD)
            begin
               if (later_i)
               begin
                  penalty_o = `VUST_PEN_A;
               end
               else
               begin
                  nxt_state_o = `VUST_ST_PRES;
                  penalty_o = `VUST_PEN_A;
               end
            end
            // Clean and preserved stay put, no cost
         end
         `VUST_OP_WIDE128, `VUST_OP_WIDE256:
         begin
            nxt_state_o = `VUST_ST_MOD;
            if (state_i == `VUST_ST_PRES && !later_i)
            begin
               penalty_o = `VUST_PEN_B;
            end
         end
         `VUST_OP_CLRUP, `VUST_OP_CLRALL:
         begin
            nxt_state_o = `VUST_ST_CLEAN;
            if (state_i == `VUST_ST_PRES && !later_i)
            begin
               penalty_o = `VUST_PEN_D;
            end
         end
         `VUST_OP_RSTOR:
         begin
            if (image_dirty_i)
            begin
               nxt_state_o = `VUST_ST_PRES;
               penalty_o = `VUST_PEN_C;
            end
            else
            begin
               nxt_state_o = `VUST_ST_CLEAN;
            end
         end
         default:
         begin
            nxt_state_o = state_i;
            penalty_o = `VUST_PEN_NONE;
         end
      endcase
   end
endmodule // vust_next_state
`default_nettype wire

// ---- rtl/vust_tracker.v ----
// Upper-half state tracker for the wide vector register collection
`timescale 1ns/1ns
`default_nettype none
`include "vust_defs.vh"
module vust_tracker
(
   input wire clk_i,
   input wire rst_n_i,
   input wire retire_valid_i,
   input wire [2:0] retire_op_i,
   input wire [3:0] retire_dst_i,
   input wire image_dirty_i,
   input wire later_impl_i,
   output wire resp_valid_o,
   output wire [1:0] state_o,
   output wire [2:0] penalty_o,
   output wire dst_dep_o,
   output wire blend_o,
   output wire upper_zero_o,
   output wire [15:0] upper_dirty_o
);
   // ****************************************
   // Declarations
   // ****************************************
   // Registered copies of every output
   reg resp_valid_ff;
   reg [1:0] state_ff;
   reg [2:0] penalty_ff;
   reg dst_dep_ff;
   reg blend_ff;
   reg upper_zero_ff;
   reg [15:0] dirty_ff;
   // Next values of the registers above
   reg nxt_resp_valid;
   reg nxt_dst_dep;
   reg nxt_blend;
   reg nxt_upper_zero;
   wire [1:0] nxt_state;
   wire [2:0] nxt_penalty;
   wire [15:0] nxt_dirty;
   // Decoded view of the retiring instruction
   wire [2:0] op_eff;
   wire is_legacy;
   wire dst_upper_live;

   // ****************************************
   // Instruction decode
   // ****************************************
   // Idle cycles look like no instruction, so stale fields do no harm
   assign op_eff = retire_valid_i ? retire_op_i : `VUST_OP_NONE;
   // Legacy writes are the only ones that can need a blend
   assign is_legacy = (op_eff == `VUST_OP_LEGACY);
   // Destination upper half still holds data from a full-width write or a dirty restore
   assign dst_upper_live = dirty_ff[retire_dst_i];

   // ****************************************
   // Tracker state and penalty lookup
   // ****************************************
   // Shared transition table; the registers below only hold its result
   vust_next_state u_next
   (
      .state_i(state_ff),
      .op_i(op_eff),
      .later_i(later_impl_i),
      .image_dirty_i(image_dirty_i),
      .nxt_state_o(nxt_state),
      .penalty_o(nxt_penalty)
   );

   // ****************************************
   // Dependency and blend in the later form
   // ****************************************
   // A legacy write in modified state merges into a live upper half, so
   // issue must wait for the old value and blend it in; a register whose
   // upper half is zero needs neither, and clean state never merges
   always @*
   begin
      nxt_dst_dep = 1'h0;
      nxt_blend = 1'h0;
      if (later_impl_i && is_legacy && (state_ff == `VUST_ST_MOD))
      begin
         nxt_dst_dep = dst_upper_live;
         nxt_blend = dst_upper_live;
      end
   end

   // ****************************************
   // Response strobe and zero flag
   // ****************************************
   // One response per retired instruction; clean means no upper bit is set
   always @*
   begin
      nxt_resp_valid = retire_valid_i;
      nxt_upper_zero = (nxt_state == `VUST_ST_CLEAN);
   end

   // ****************************************
   // Per-register upper-bit tracking
   // ****************************************
   // One mask bit per register: its upper half may hold non-zero data
   genvar g;
   generate
      for (g = 0; g < `VUST_NREG; g = g + 1)
      begin : g_reg
         reg nxt_bit;
         always @*
         begin
            nxt_bit = dirty_ff[g];
            case (op_eff)
               `VUST_OP_WIDE128:
               begin
                  // Upper half forced to zero on the destination
                  if (retire_dst_i == g)
                  begin
                     nxt_bit = 1'h0;
                  end
               end
               `VUST_OP_WIDE256:
               begin
                  // Full-width write leaves live data in the upper half
                  if (retire_dst_i == g)
                  begin
                     nxt_bit = 1'h1;
                  end
               end
               `VUST_OP_CLRUP, `VUST_OP_CLRALL:
               begin
                  nxt_bit = 1'h0;
               end
               `VUST_OP_RSTOR:
               begin
                  // A dirty image may leave any register with upper data
                  nxt_bit = image_dirty_i;
               end
               default:
               begin
                  // Legacy writes leave the upper bits alone
                  nxt_bit = dirty_ff[g];
               end
            endcase
         end
         assign nxt_dirty[g] = nxt_bit;
      end
   endgenerate

   // ****************************************
   // Registered results
   // ****************************************
   // Tracker state; a clear lands on its own retiring edge, seen one cycle after the retire
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_ff <= `VUST_ST_CLEAN;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // Penalty code, meaningful in the response cycle only
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         penalty_ff <= `VUST_PEN_NONE;
      end
      else
      begin
         penalty_ff <= nxt_penalty;
      end
   end

   // Response strobe, one cycle per retired instruction
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         resp_valid_ff <= `VUST_FLAG_RST;
      end
      else
      begin
         resp_valid_ff <= nxt_resp_valid;
      end
   end

   // Dependency and blend requests to the issue logic
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         dst_dep_ff <= `VUST_FLAG_RST;
         blend_ff <= `VUST_FLAG_RST;
      end
      else
      begin
         dst_dep_ff <= nxt_dst_dep;
         blend_ff <= nxt_blend;
      end
   end

   // Upper-zero flag, set whenever the tracker is clean
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         upper_zero_ff <= `VUST_ZERO_RST;
      end
      else
      begin
         upper_zero_ff <= nxt_upper_zero;
      end
   end

   // Per-register upper mask, all clear out of reset
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         dirty_ff <= `VUST_MASK_RST;
      end
      else
      begin
         dirty_ff <= nxt_dirty;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Every output is a plain copy of its register
   assign resp_valid_o = resp_valid_ff;
   assign state_o = state_ff;
   assign penalty_o = penalty_ff;
   assign dst_dep_o = dst_dep_ff;
   assign blend_o = blend_ff;
   assign upper_zero_o = upper_zero_ff;
   assign upper_dirty_o = dirty_ff;
endmodule // vust_tracker
`default_nettype wire

// ---- sim/vust_tracker_sva.sv ----
// Checker of the upper-half state tracker
`timescale 1ns/1ns
`default_nettype none
module vust_tracker_sva
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic retire_valid_i,
   input wire logic [2:0] retire_op_i,
   input wire logic image_dirty_i,
   input wire logic later_impl_i,
   input wire logic resp_valid_o,
   input wire logic [1:0] state_o,
   input wire logic [2:0] penalty_o,
   input wire logic [15:0] upper_dirty_o,
   input wire logic dst_dep_o,
   input wire logic blend_o,
   input wire logic upper_zero_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Short aliases
   wire logic v = retire_valid_i;
   wire logic [2:0] o = retire_op_i;
   wire logic d = image_dirty_i;
   wire logic e = !later_impl_i;
   wire logic [1:0] s = state_o;
   wire logic [2:0] p = penalty_o;
   a_resp_pulse: assert property (v |=> resp_valid_o)
      else $error("missing response");
   a_wide_mod: assert property (v && o[2:1] == 2'h1 |=> s == 2'h1)
      else $error("wide op not modified");
   a_clear_clean: assert property (v && o == 3'h4 |=> s == 2'h0 && !upper_dirty_o)
      else $error("clear-upper not clean");
   a_dirty_rst: assert property (v && o == 3'h5 && d |=> s == 2'h2 && p == 3'h3)
      else $error("dirty restore wrong");
   a_clean_rst: assert property (v && o == 3'h5 && !d |=> s == 2'h0 && p == 3'h0)
      else $error("clean restore wrong");
   a_leg_mod: assert property (v && o == 3'h1 && e && s == 2'h1
      |=> s == 2'h2 && p == 3'h1)
      else $error("legacy in modified wrong");
   a_pres_wide: assert property (v && o[2:1] == 2'h1 && e && s == 2'h2 |=> p == 3'h2)
      else $error("wide in preserved wrong");
   a_clean_free: assert property (v && s == 2'h0 && o != 3'h5 |=> p == 3'h0)
      else $error("penalty from clean");
   a_later_leg: assert property (v && o == 3'h1 && !e && s == 2'h1
      |=> s == 2'h1 && p == 3'h1)
      else $error("later legacy in modified wrong");
   a_pres_clear: assert property (v && (o == 3'h4 || o == 3'h6) && e && s == 2'h2
      |=> s == 2'h0 && p == 3'h4)
      else $error("clear from preserved wrong");
   a_blend_mod: assert property (blend_o |-> s == 2'h1)
      else $error("blend outside modified state");
   a_zero_mask: assert property (upper_zero_o |-> upper_dirty_o == 16'h0000)
      else $error("clean with upper bits set");
endmodule // vust_tracker_sva
bind vust_tracker vust_tracker_sva u_sva
(
   .clk_i(clk_i),
   .rst_n_i(rst_n_i),
   .retire_valid_i(retire_valid_i),
   .retire_op_i(retire_op_i),
   .image_dirty_i(image_dirty_i),
   .later_impl_i(later_impl_i),
   .resp_valid_o(resp_valid_o),
   .state_o(state_o),
   .penalty_o(penalty_o),
   .upper_dirty_o(upper_dirty_o),
   .dst_dep_o(dst_dep_o),
   .blend_o(blend_o),
   .upper_zero_o(upper_zero_o)
);
`default_nettype wire

// ---- sim/vust_issue_model.sv ----
// Issue-side model retiring vector instructions into the tracker
`timescale 1ns/1ns
`default_nettype none
module vust_issue_model
(
   input wire logic clk_i,
   output logic valid_o,
   output logic [2:0] op_o,
   output logic [3:0] dst_o,
   output logic dirty_o,
   output logic later_o
);
   initial {valid_o, op_o, dst_o, dirty_o, later_o} = 10'h000;
   // Holds one op over one edge, then scrambles the idle fields
   // Clear-upper between blocks is left to the caller
   // Images are clean unless a dirty restore is asked for
   task issue(input logic [2:0] o, input logic [3:0] d, input logic k);
      @(posedge clk_i);
      valid_o <= 1'h1;
      {op_o, dst_o, dirty_o} <= {o, d, k};
      @(posedge clk_i);
      valid_o <= 1'h0;
      {op_o, dst_o, dirty_o} <= ~{o, d, k};
   endtask
   // Switches between the earlier and the later implementation
   task set_later(input logic l);
      @(posedge clk_i);
      later_o <= l;
   endtask
endmodule // vust_issue_model
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench of the upper-half state tracker
`timescale 1ns/1ns
`default_nettype none
`include "vust_defs.vh"
module tb;
   logic clk, rst_n;
   wire logic vld, dirty, later, rv, uz, dep, bl;
   wire logic [2:0] op, pen;
   wire logic [3:0] dst;
   wire logic [1:0] st;
   wire logic [15:0] msk;
   int errors = 0;
   int tests_run = 0;
   vust_issue_model m (.clk_i(clk), .valid_o(vld), .op_o(op), .dst_o(dst),
      .dirty_o(dirty), .later_o(later));
   vust_tracker dut (.clk_i(clk), .rst_n_i(rst_n), .retire_valid_i(vld),
      .retire_op_i(op), .retire_dst_i(dst), .image_dirty_i(dirty),
      .later_impl_i(later), .resp_valid_o(rv), .state_o(st), .penalty_o(pen),
      .dst_dep_o(dep), .blend_o(bl), .upper_zero_o(uz), .upper_dirty_o(msk));
   // Compares one value and counts it
   task check(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e)
      begin
         errors++;
         $display("BAD %0t %h %h", $time, s, e);
      end
   endtask
   // Retires one op (dirty image from dst bit 0) and checks the answer
   task go(input logic [2:0] o, input logic [3:0] d, input logic [1:0] s, input logic [2:0] p);
      m.issue(o, d, d[0]);
      #1;
      check({rv, st, pen}, {1'h1, s, p});
   endtask
   task t_reset;
      #1;
      check({st, uz, msk}, 19'h10000);
      $display("reset test done");
   endtask
   task t_earlier;
      go(`VUST_OP_LEGACY, 4'h1, 2'h0, 3'h0);
      go(`VUST_OP_WIDE256, 4'h2, 2'h1, 3'h0);
      check({uz, msk[2]}, 2'h1);
      go(`VUST_OP_WIDE128, 4'h4, 2'h1, 3'h0);
      go(`VUST_OP_LEGACY, 4'h2, 2'h2, 3'h1);
      go(`VUST_OP_LEGACY, 4'h3, 2'h2, 3'h0);
      go(`VUST_OP_WIDE128, 4'h2, 2'h1, 3'h2);
      go(`VUST_OP_LEGACY, 4'h2, 2'h2, 3'h1);
      go(`VUST_OP_CLRUP, 4'h0, 2'h0, 3'h4);
      check({uz, msk}, 17'h10000);
      $display("earlier test done");
   endtask
   task t_restore;
      go(`VUST_OP_RSTOR, 4'h1, 2'h2, 3'h3);
      check(msk, 16'hFFFF);
      go(`VUST_OP_SAVE, 4'h0, 2'h2, 3'h0);
      go(`VUST_OP_CLRALL, 4'h0, 2'h0, 3'h4);
      go(`VUST_OP_RSTOR, 4'h0, 2'h0, 3'h0);
      $display("restore test done");
   endtask
   task t_later;
      m.set_later(1'h1);
      go(`VUST_OP_WIDE256, 4'h2, 2'h1, 3'h0);
      go(`VUST_OP_LEGACY, 4'h2, 2'h1, 3'h1);
      check({dep, bl}, 2'h3);
      go(`VUST_OP_CLRUP, 4'h0, 2'h0, 3'h0);
      go(`VUST_OP_LEGACY, 4'h2, 2'h0, 3'h0);
      check({dep, bl}, 2'h0);
      go(`VUST_OP_RSTOR, 4'h1, 2'h2, 3'h3);
      go(`VUST_OP_WIDE128, 4'h1, 2'h1, 3'h0);
      go(`VUST_OP_LEGACY, 4'h1, 2'h1, 3'h1);
      check({dep, bl}, 2'h0);
      go(`VUST_OP_LEGACY, 4'h3, 2'h1, 3'h1);
      check({dep, bl}, 2'h3);
      $display("later test done");
   endtask
   // Resets in mid-run from modified state with upper bits set
   task t_mid_reset;
      @(posedge clk);
      rst_n <= 1'h0;
      @(posedge clk);
      #1;
      check({rv, st, uz, msk}, 20'h10000);
      @(posedge clk);
      rst_n <= 1'h1;
      go(`VUST_OP_LEGACY, 4'h3, 2'h0, 3'h0);
      check({dep, bl}, 2'h0);
      $display("mid reset test done");
   endtask
   task report_and_stop;
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   initial
   begin
      rst_n = 1'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      t_reset;
      t_earlier;
      t_restore;
      t_later;
      t_mid_reset;
      report_and_stop;
   end
   // Watchdog
   initial
   begin
      #30000;
      errors++;
      report_and_stop;
   end
endmodule // tb
`default_nettype wire
